// ---- shared/block_memory_pkg.sv ----
// Shared constants and types for the embedded block memory.
`default_nettype none
package block_memory_pkg;

	// Array shape: four byte lanes of 512 nine-bit entries hold 18 kilobits of data and parity.
	localparam int ADDR_W = 14;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int ROWS = 512;
	localparam int ROW_W = 9;
	localparam int BYTE_W = 11;

	typedef enum logic [2:0] {
		WIDTH_X1 = 3'h0,
		WIDTH_X2 = 3'h1,
		WIDTH_X4 = 3'h2,
		WIDTH_X9 = 3'h3,
		WIDTH_X18 = 3'h4,
		WIDTH_X36 = 3'h5
	} width_t;

	typedef enum logic [1:0] {
		WMODE_NORMAL = 2'h0,
		WMODE_THROUGH = 2'h1,
		WMODE_RBW = 2'h2
	} wmode_t;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_TRUE_DUAL = 2'h1,
		MODE_PSEUDO_DUAL = 2'h2,
		MODE_ROM = 2'h3
	} mem_mode_t;

	// Register indices on the plain register port.
	localparam int REG_ADDR_W = 4;
	localparam logic [3:0] CFG_IDX = 4'h0;
	localparam logic [3:0] LOAD_ADDR_IDX = 4'h1;
	localparam logic [3:0] LOAD_DATA_IDX = 4'h2;
	localparam logic [3:0] STATUS_IDX = 4'h3;

	// Configuration register fields.
	localparam int CFG_WIDTH_A_LSB = 0;
	localparam int CFG_WMODE_A_LSB = 6;
	localparam int CFG_OUTREG_A = 10;
	localparam int CFG_SYNCRST_A = 12;
	localparam int CFG_PARITY = 14;
	localparam int CFG_MODE_LSB = 15;
	localparam int CFG_BITS = 17;
	localparam logic [16:0] CFG_RESET = 17'h00000;

	// Status register fields.
	localparam int STAT_COLLIDE = 0;
	localparam int STAT_DEMOTED = 1;

	// Clears the ninth bit of every byte when parity storage is off.
	localparam logic [35:0] NO_PARITY_MASK = 36'h7fbfdfeff;

endpackage
`default_nettype wire

// ---- design/embedded_block_memory.sv ----
// Embedded block memory with two ports, selectable widths, write modes and output reset.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE1: 18 kilobits, widths x1 to x36.
// RULE2: True dual port stops at x18.
// RULE3: Optional parity bit per stored byte.
// RULE4: Byte enables at x18 and x36.
// RULE5: Each port picks its own width.
// RULE6: Word zero sits in lowest bits.
// RULE7: Preloadable contents; writes off gives ROM.
// RULE8: Address and write data registered first.
// RULE9: Optional output register adds one cycle.
// RULE10: Normal mode: output changes on reads only.
// RULE11: Write through shows written data.
// RULE12: Read before write shows old data; at x1, x2 and x4 the mode falls back to normal.
// RULE13: Port registers use own clock enable.
// RULE14: Each local reset clears own output.
// RULE15: Output reset asynchronous or synchronous; asynchronous mode here clears at the next clock edge, ignoring the enable.
// RULE16: Global reset clears both outputs.
// RULE17: Same-address dual writes are undefined.
module embedded_block_memory (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic global_reset_n_i,
	input wire logic a_ce_i,
	input wire logic a_we_i,
	input wire logic [13:0] a_addr_i,
	input wire logic [35:0] a_wdata_i,
	input wire logic [3:0] a_be_i,
	input wire logic port_a_output_reset_i,
	output logic [35:0] a_rdata_o,
	input wire logic b_ce_i,
	input wire logic b_we_i,
	input wire logic [13:0] b_addr_i,
	input wire logic [35:0] b_wdata_i,
	input wire logic [3:0] b_be_i,
	input wire logic port_b_output_reset_i,
	output logic [35:0] b_rdata_o,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o
);

	function automatic logic [10:0] byte_of(input logic [2:0] w, input logic [13:0] a);
		case (w)
			block_memory_pkg::WIDTH_X1: byte_of = a[13:3];
			block_memory_pkg::WIDTH_X2: byte_of = a[12:2];
			block_memory_pkg::WIDTH_X4: byte_of = a[11:1];
			block_memory_pkg::WIDTH_X9: byte_of = a[10:0];
			block_memory_pkg::WIDTH_X18: byte_of = {a[9:0], 1'b0};
			default: byte_of = {a[8:0], 2'b00};
		endcase
	endfunction

	function automatic logic [2:0] bitoff_of(input logic [2:0] w, input logic [13:0] a);
		case (w)
			block_memory_pkg::WIDTH_X1: bitoff_of = a[2:0];
			block_memory_pkg::WIDTH_X2: bitoff_of = {a[1:0], 1'b0};
			block_memory_pkg::WIDTH_X4: bitoff_of = {a[0], 2'b00};
			default: bitoff_of = 3'h0;
		endcase
	endfunction

	function automatic logic [7:0] nmask_of(input logic [2:0] w);
		case (w)
			block_memory_pkg::WIDTH_X1: nmask_of = 8'h01;
			block_memory_pkg::WIDTH_X2: nmask_of = 8'h03;
			block_memory_pkg::WIDTH_X4: nmask_of = 8'h0f;
			default: nmask_of = 8'hff;
		endcase
	endfunction

	logic [block_memory_pkg::CFG_BITS-1:0] cfg_q;
	logic [block_memory_pkg::BYTE_W-1:0] load_addr_q;
	logic collide_q;
	logic [31:0] rdata_q;

	// Cross-port buses are nets so that each generate branch drives its own slice.
	wire [1:0][3:0] wen_all;
	wire [1:0][3:0][8:0] wdat_all;
	wire [1:0][3:0][8:0] wmask_all;
	wire [1:0][8:0] row_all;
	wire [1:0][3:0][8:0] rd_all;
	wire [1:0][35:0] dout_all;

	wire [1:0] mem_mode;
	wire parity_en;
	wire [35:0] parity_keep;
	wire [1:0] read_ok;
	wire [1:0] write_ok;
	wire [1:0] demote;
	wire [1:0] ce_in;
	wire [1:0] we_in;
	wire [1:0] rst_in;
	wire [13:0] addr_in [2];
	wire [35:0] wdata_in [2];
	wire [3:0] be_in [2];
	wire cfg_wr;
	wire load_addr_wr;
	wire load_we;
	wire status_wr;
	wire collide_ev;
	wire [31:0] rd_mux;

	assign mem_mode = cfg_q[block_memory_pkg::CFG_MODE_LSB +: 2];
	assign parity_en = cfg_q[block_memory_pkg::CFG_PARITY];
	assign parity_keep = parity_en ? 36'hfffffffff : block_memory_pkg::NO_PARITY_MASK; // RULE3

	// Pseudo dual port writes on A and reads on B; ROM mode keeps both ports read-only.
	assign read_ok[0] = mem_mode != block_memory_pkg::MODE_PSEUDO_DUAL;
	assign read_ok[1] = mem_mode != block_memory_pkg::MODE_SINGLE;
	assign write_ok[0] = mem_mode != block_memory_pkg::MODE_ROM; // RULE7
	assign write_ok[1] = mem_mode == block_memory_pkg::MODE_TRUE_DUAL;

	assign ce_in = {b_ce_i, a_ce_i};
	assign we_in = {b_we_i, a_we_i};
	assign rst_in = {port_b_output_reset_i, port_a_output_reset_i};
	assign addr_in[0] = a_addr_i;
	assign addr_in[1] = b_addr_i;
	assign wdata_in[0] = a_wdata_i;
	assign wdata_in[1] = b_wdata_i;
	assign be_in[0] = a_be_i;
	assign be_in[1] = b_be_i;

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [13:0] addr_q;
		logic [35:0] wdata_q;
		logic [3:0] be_q;
		logic we_q;
		logic acc_q;
		logic [35:0] latch_q;
		logic [35:0] dout_q;
		wire [2:0] wcfg;
		wire [2:0] w;
		wire [1:0] wmode;
		wire outreg;
		wire syncrst;
		wire clr;
		wire is_narrow;
		wire upd;
		wire we_ok;
		wire [10:0] byte_idx;
		wire [2:0] bitoff;
		wire [7:0] nmask;
		wire [1:0] lanesel;
		wire [8:0] lane_rd;
		wire [35:0] rword;
		wire [35:0] tword;
		wire [35:0] newval;

		assign wcfg = cfg_q[block_memory_pkg::CFG_WIDTH_A_LSB + 3*p +: 3]; // RULE5
		assign demote[p] = (mem_mode == block_memory_pkg::MODE_TRUE_DUAL) && (wcfg >= block_memory_pkg::WIDTH_X36);
		assign w = demote[p] ? block_memory_pkg::WIDTH_X18 : wcfg; // RULE2
		assign wmode = cfg_q[block_memory_pkg::CFG_WMODE_A_LSB + 2*p +: 2];
		assign outreg = cfg_q[block_memory_pkg::CFG_OUTREG_A + p];
		assign syncrst = cfg_q[block_memory_pkg::CFG_SYNCRST_A + p];
		assign is_narrow = w < block_memory_pkg::WIDTH_X9;
		assign byte_idx = byte_of(w, addr_q); // RULE1 RULE6
		assign bitoff = bitoff_of(w, addr_q); // RULE6
		assign nmask = nmask_of(w);
		assign lanesel = (w == block_memory_pkg::WIDTH_X18) ? 2'h1 : (w > block_memory_pkg::WIDTH_X18) ? 2'h3 : 2'h0;
		assign row_all[p] = byte_idx[10:2];
		assign we_ok = we_in[p] & write_ok[p];

		for (genvar L = 0; L < 4; L++) begin : g_wlane
			localparam logic [1:0] LN = 2'(L);
			wire lane_hit;
			wire be_ok;
			assign lane_hit = (w > block_memory_pkg::WIDTH_X18) |
				((w == block_memory_pkg::WIDTH_X18) ? (byte_idx[1] == LN[1]) : (byte_idx[1:0] == LN));
			assign be_ok = (w < block_memory_pkg::WIDTH_X18) | be_q[LN & lanesel]; // RULE4
			assign wen_all[p][L] = acc_q & we_q & lane_hit & be_ok;
			assign wmask_all[p][L] = is_narrow ? {1'b0, nmask << bitoff} : 9'h1ff;
			assign wdat_all[p][L] = (is_narrow ? {1'b0, (wdata_q[7:0] & nmask) << bitoff} :
				wdata_q[9*(LN & lanesel) +: 9]) & {parity_en, 8'hff}; // RULE3
		end

		assign lane_rd = rd_all[p][byte_idx[1:0]];
		assign rword = parity_keep & (
			(w == block_memory_pkg::WIDTH_X18) ?
				(byte_idx[1] ? {18'h0, rd_all[p][3], rd_all[p][2]} : {18'h0, rd_all[p][1], rd_all[p][0]}) :
			(w == block_memory_pkg::WIDTH_X9) ? {27'h0, lane_rd} :
			is_narrow ? {28'h0, (lane_rd[7:0] >> bitoff) & nmask} :
			{rd_all[p][3], rd_all[p][2], rd_all[p][1], rd_all[p][0]}); // RULE6
		assign tword = parity_keep & (
			is_narrow ? {28'h0, wdata_q[7:0] & nmask} :
			(w == block_memory_pkg::WIDTH_X9) ? {27'h0, wdata_q[8:0]} :
			(w == block_memory_pkg::WIDTH_X18) ? {18'h0, wdata_q[17:0]} : wdata_q);

		// Narrow widths have no read-before-write path, so that mode falls back to normal there.
		assign upd = ~we_q | (wmode == block_memory_pkg::WMODE_THROUGH) |
			((wmode == block_memory_pkg::WMODE_RBW) & ~is_narrow); // RULE10 RULE12
		assign newval = (we_q && wmode == block_memory_pkg::WMODE_THROUGH) ? tword : rword; // RULE11 RULE12

		// Asynchronous mode clears on any edge; synchronous mode waits for an enabled edge.
		assign clr = (rst_in[p] | ~global_reset_n_i) & (~syncrst | ce_in[p]); // RULE14 RULE15 RULE16

		always_ff @(posedge sys_clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				addr_q <= 14'h0;
				wdata_q <= 36'h0;
				be_q <= 4'h0;
				we_q <= 1'b0;
				acc_q <= 1'b0;
			end else begin
				acc_q <= ce_in[p] & (we_ok | read_ok[p]); // RULE13
				if (ce_in[p]) begin
					addr_q <= addr_in[p]; // RULE8
					wdata_q <= wdata_in[p]; // RULE8
					be_q <= be_in[p];
					we_q <= we_ok;
				end
			end
		end

		always_ff @(posedge sys_clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				latch_q <= 36'h0;
				dout_q <= 36'h0;
			end else if (clr) begin
				latch_q <= 36'h0; // RULE14 RULE16
				dout_q <= 36'h0;
			end else begin
				if (acc_q && upd) begin
					latch_q <= newval;
				end
				if (outreg) begin
					if (ce_in[p]) begin
						dout_q <= latch_q; // RULE9 RULE13
					end
				end else if (acc_q && upd) begin
					dout_q <= newval; // RULE10
				end
			end
		end

		assign dout_all[p] = dout_q;
	end

	// Port B is applied after port A, so a same-byte collision leaves B's merge in place.
	for (genvar L = 0; L < 4; L++) begin : g_lane
		localparam logic [1:0] LN = 2'(L);
		logic [8:0] mem [block_memory_pkg::ROWS];

		always_ff @(posedge sys_clk_i) begin
			if (load_we && load_addr_q[1:0] == LN) begin
				mem[load_addr_q[10:2]] <= reg_wdata_i[8:0]; // RULE7
			end
			for (int p = 0; p < 2; p++) begin
				if (wen_all[p][L]) begin
					mem[row_all[p]] <= (mem[row_all[p]] & ~wmask_all[p][L]) | (wdat_all[p][L] & wmask_all[p][L]);
				end
			end
		end

		assign rd_all[0][L] = mem[row_all[0]];
		assign rd_all[1][L] = mem[row_all[1]];
	end

	assign collide_ev = (row_all[0] == row_all[1]) & (|(wen_all[0] & wen_all[1])); // RULE17

	assign cfg_wr = reg_we_i & (reg_addr_i == block_memory_pkg::CFG_IDX);
	assign load_addr_wr = reg_we_i & (reg_addr_i == block_memory_pkg::LOAD_ADDR_IDX);
	assign load_we = reg_we_i & (reg_addr_i == block_memory_pkg::LOAD_DATA_IDX);
	assign status_wr = reg_we_i & (reg_addr_i == block_memory_pkg::STATUS_IDX);
	assign rd_mux =
		(reg_addr_i == block_memory_pkg::CFG_IDX) ? {15'h0, cfg_q} :
		(reg_addr_i == block_memory_pkg::LOAD_ADDR_IDX) ? {21'h0, load_addr_q} :
		(reg_addr_i == block_memory_pkg::STATUS_IDX) ? {30'h0, |demote, collide_q} : 32'h0;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_q <= block_memory_pkg::CFG_RESET;
			load_addr_q <= 11'h0;
			collide_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			if (cfg_wr) begin
				cfg_q <= reg_wdata_i[block_memory_pkg::CFG_BITS-1:0];
			end
			if (load_addr_wr) begin
				load_addr_q <= reg_wdata_i[10:0];
			end else if (load_we) begin
				load_addr_q <= load_addr_q + 11'h1; // RULE7
			end
			// A collision in the clearing cycle still sets the flag.
			collide_q <= collide_ev | (collide_q & ~(status_wr & reg_wdata_i[block_memory_pkg::STAT_COLLIDE])); // RULE17
			rdata_q <= reg_re_i ? rd_mux : 32'h0;
		end
	end

	assign a_rdata_o = dout_all[0];
	assign b_rdata_o = dout_all[1];
	assign reg_rdata_o = rdata_q;

endmodule // embedded_block_memory
`default_nettype wire

// ---- sim/block_memory_asserts.sv ----
// Port-level assertions for the embedded block memory.
`timescale 1ns/1ns
`default_nettype none
module block_memory_checker (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic global_reset_n_i,
	input wire logic a_ce_i,
	input wire logic port_a_output_reset_i,
	input wire logic [35:0] a_rdata_o,
	input wire logic b_ce_i,
	input wire logic port_b_output_reset_i,
	input wire logic [35:0] b_rdata_o,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [31:0] reg_rdata_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	both_cleared_a: assert property (!global_reset_n_i && a_ce_i && b_ce_i |=> a_rdata_o == 36'h0 && b_rdata_o == 36'h0)
		else $error("global reset left an output set");
	a_cleared_a: assert property (port_a_output_reset_i && a_ce_i |=> a_rdata_o == 36'h0)
		else $error("port a reset left its output set");
	b_isolated_a: assert property (port_a_output_reset_i && global_reset_n_i && !port_b_output_reset_i && !b_ce_i
		&& !$past(b_ce_i) |=> $stable(b_rdata_o)) else $error("port a reset moved port b output");
	a_cause_a: assert property ($changed(a_rdata_o) |-> $past(a_ce_i) || $past(a_ce_i, 2)
		|| $past(port_a_output_reset_i) || !$past(global_reset_n_i)) else $error("port a output moved alone");
	b_cause_a: assert property ($changed(b_rdata_o) |-> $past(b_ce_i) || $past(b_ce_i, 2)
		|| $past(port_b_output_reset_i) || !$past(global_reset_n_i)) else $error("port b output moved alone");
	reg_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
		else $error("register data without a read");
	reg_unmapped_a: assert property (reg_re_i && reg_addr_i > block_memory_pkg::STATUS_IDX |=> reg_rdata_o == 32'h0)
		else $error("unmapped register read not zero");
	cfg_back_a: assert property (reg_we_i && reg_addr_i == block_memory_pkg::CFG_IDX ##1 reg_re_i && !reg_we_i
		&& reg_addr_i == block_memory_pkg::CFG_IDX |=> reg_rdata_o == {15'h0, $past(reg_wdata_i[16:0], 2)})
		else $error("configuration read back wrong");
	cover property (port_a_output_reset_i && a_ce_i);
	cover property (!global_reset_n_i && a_ce_i && b_ce_i);
	cover property (reg_we_i ##1 reg_re_i);
endmodule // block_memory_checker
bind embedded_block_memory block_memory_checker chk_u (.sys_clk_i, .nrst_i, .global_reset_n_i, .a_ce_i,
	.port_a_output_reset_i, .a_rdata_o, .b_ce_i, .port_b_output_reset_i, .b_rdata_o, .reg_addr_i, .reg_wdata_i,
	.reg_we_i, .reg_re_i, .reg_rdata_o);
`default_nettype wire

// ---- sim/fabric_port_model.sv ----
// Fabric logic that reads through the second memory port when told to.
`timescale 1ns/1ns
`default_nettype none
module fabric_port_model (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic go_i,
	input wire logic [13:0] addr_i,
	output logic ce_o,
	output logic [13:0] addr_o
);
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ce_o <= 1'b0;
			addr_o <= 14'h0;
		end else if (go_i) begin
			// Reads only, so the two ports can never collide on one address.
			ce_o <= 1'b1;
			addr_o <= addr_i;
		end else begin
			// Idle address toggles so the memory cannot lean on a stale value.
			ce_o <= 1'b0;
			addr_o <= ~addr_o;
		end
	end
endmodule // fabric_port_model
`default_nettype wire

// ---- sim/test_embedded_block_memory.sv ----
// Self-checking bench for the embedded block memory.
`timescale 1ns/1ns
`default_nettype none
module test_embedded_block_memory;
	logic sys_clk_i = 1'b0, nrst_i = 1'b0, global_reset_n_i = 1'b1, a_ce_i = 1'b0, a_we_i = 1'b0;
	logic port_a_output_reset_i = 1'b0, port_b_output_reset_i = 1'b0, go = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
	logic b_ce_i;
	logic [13:0] a_addr_i = 14'h0, gaddr = 14'h0, b_addr_i;
	logic [35:0] a_wdata_i = 36'h0, a_rdata_o, b_rdata_o;
	logic [3:0] a_be_i = 4'hf, reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	int num_errors = 0, checks = 0, cycles = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	embedded_block_memory dut_u (.sys_clk_i, .nrst_i, .global_reset_n_i, .a_ce_i, .a_we_i, .a_addr_i, .a_wdata_i,
		.a_be_i, .port_a_output_reset_i, .a_rdata_o, .b_ce_i, .b_we_i(1'b0), .b_addr_i, .b_wdata_i(36'h0),
		.b_be_i(4'hf), .port_b_output_reset_i, .b_rdata_o, .reg_addr_i, .reg_wdata_i, .reg_we_i,
		.reg_re_i, .reg_rdata_o);
	fabric_port_model model_u (.sys_clk_i, .nrst_i, .go_i(go), .addr_i(gaddr), .ce_o(b_ce_i), .addr_o(b_addr_i));
	task automatic give_verdict();
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge sys_clk_i);
		#1;
	endtask
	// Every access task returns just after an edge, so no strobe is assigned twice in one step.
	task automatic regw(input logic [3:0] idx, input logic [31:0] val);
		reg_we_i <= 1'b1;
		reg_addr_i <= idx;
		reg_wdata_i <= val;
		@(posedge sys_clk_i);
		reg_we_i <= 1'b0;
		#1;
	endtask
	task automatic regr(input logic [3:0] idx, input logic [31:0] exp);
		reg_re_i <= 1'b1;
		reg_addr_i <= idx;
		@(posedge sys_clk_i);
		reg_re_i <= 1'b0;
		#1;
		chk("register", {4'h0, exp}, {4'h0, reg_rdata_o});
	endtask
	task automatic put_a(input logic we, input logic [13:0] addr, input logic [35:0] data, input logic [3:0] be,
		input logic keep);
		a_ce_i <= 1'b1;
		a_we_i <= we;
		a_addr_i <= addr;
		a_wdata_i <= data;
		a_be_i <= be;
		@(posedge sys_clk_i);
		a_ce_i <= keep;
		a_we_i <= 1'b0;
		tick();
	endtask
	task automatic put_b(input logic [13:0] addr);
		go <= 1'b1;
		gaddr <= addr;
		@(posedge sys_clk_i);
		go <= 1'b0;
		@(posedge sys_clk_i);
		tick();
	endtask
	task automatic write_modes();
		regr(4'h0, 32'h0);
		regw(4'h0, 32'h0000c05b);
		regr(4'h0, 32'h0000c05b);
		regr(4'h9, 32'h0);
		put_a(1'b1, 14'h5, 36'h1a5, 4'hf, 1'b0);
		chk("through", 36'h1a5, a_rdata_o);
		put_b(14'h5);
		chk("parity", 36'h1a5, b_rdata_o);
		regw(4'h0, 32'h0000c01b);
		put_a(1'b1, 14'h5, 36'h0c3, 4'hf, 1'b0);
		chk("normal", 36'h1a5, a_rdata_o);
		put_b(14'h5);
		chk("stored", 36'h0c3, b_rdata_o);
		regw(4'h0, 32'h0000c09b);
		put_a(1'b1, 14'h5, 36'h15a, 4'hf, 1'b0);
		chk("old", 36'h0c3, a_rdata_o);
	endtask
	task automatic widths();
		regw(4'h0, 32'h0000c003);
		put_b(14'd40);
		chk("bit zero", 36'h0, b_rdata_o);
		put_b(14'd41);
		chk("bit one", 36'h1, b_rdata_o);
		regw(4'h0, 32'h0000c01c);
		put_a(1'b1, 14'h2, {18'h0, 9'h1f0, 9'h00f}, 4'h3, 1'b0);
		put_a(1'b1, 14'h2, {18'h0, 9'h111, 9'h022}, 4'h2, 1'b0);
		put_b(14'h4);
		chk("low byte", 36'h00f, b_rdata_o);
		put_b(14'h5);
		chk("high byte", 36'h111, b_rdata_o);
	endtask
	task automatic out_register();
		regw(4'h0, 32'h0000c01b);
		put_a(1'b0, 14'h4, 36'h0, 4'hf, 1'b0);
		regw(4'h0, 32'h0000c41b);
		put_a(1'b0, 14'h5, 36'h0, 4'hf, 1'b1);
		chk("stage one", 36'h00f, a_rdata_o);
		tick();
		chk("stage two", 36'h111, a_rdata_o);
		a_ce_i <= 1'b0;
	endtask
	task automatic rom_load();
		regw(4'h1, 32'd12);
		regw(4'h2, 32'h0e7);
		regw(4'h0, 32'h00018003);
		put_a(1'b1, 14'd12, 36'h055, 4'hf, 1'b0);
		put_a(1'b0, 14'd12, 36'h0, 4'hf, 1'b0);
		chk("rom", 36'h0e7, a_rdata_o);
	endtask
	task automatic out_resets();
		port_a_output_reset_i <= 1'b1;
		a_ce_i <= 1'b1;
		@(posedge sys_clk_i);
		port_a_output_reset_i <= 1'b0;
		a_ce_i <= 1'b0;
		// The read taken beside the reset lands one edge later, so the cleared value stands only now.
		#1;
		chk("a reset", 36'h0, a_rdata_o);
		chk("b kept", 36'h111, b_rdata_o);
		go <= 1'b1;
		@(posedge sys_clk_i);
		go <= 1'b0;
		global_reset_n_i <= 1'b0;
		a_ce_i <= 1'b1;
		@(posedge sys_clk_i);
		global_reset_n_i <= 1'b1;
		a_ce_i <= 1'b0;
		#1;
		chk("a global", 36'h0, a_rdata_o);
		chk("b global", 36'h0, b_rdata_o);
	endtask
	task automatic b_reset_status();
		regw(4'h0, 32'h0000e02b);
		regr(4'h3, 32'h2);
		put_b(14'h2);
		chk("demoted", 36'h2220f, b_rdata_o);
		go <= 1'b1;
		gaddr <= 14'h2;
		port_b_output_reset_i <= 1'b1;
		@(posedge sys_clk_i);
		go <= 1'b0;
		#1;
		chk("b sync hold", 36'h2220f, b_rdata_o);
		@(posedge sys_clk_i);
		port_b_output_reset_i <= 1'b0;
		#1;
		chk("b sync clear", 36'h0, b_rdata_o);
		chk("a kept", 36'h0e7, a_rdata_o);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		#1;
		write_modes();
		widths();
		out_register();
		rom_load();
		out_resets();
		b_reset_status();
		give_verdict();
	end
endmodule // test_embedded_block_memory
`default_nettype wire
